// ---- ccd_pkg.sv ----
package ccd_pkg;
   // ************************************
   // register map
   // ************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] CLUSTER_OFS = 8'h00;
   localparam logic [7:0] CORE_OFS = 8'h04;
   localparam logic [7:0] MEMORY_OFS = 8'h08;
   localparam logic [7:0] LANE_OFS = 8'h0C;
   localparam logic [7:0] CONTROL_OFS = 8'h10;
   localparam logic [7:0] STATUS_OFS = 8'h14;
   // ************************************
   // field positions
   // ************************************
   localparam int CLU_RATIO_W = 5;
   localparam int CLU_RANGE_POS = 20;
   localparam int CORE_SEL_W = 4;
   localparam int MEM_SYNC_POS = 0;
   localparam int MEM_RATE_POS = 1;
   localparam int MEM_RSV_POS = 2;
   localparam int MEM_RANGE_POS = 8;
   localparam int MEM_RATIO_POS = 10;
   localparam int LANE_RATIO_STEP = 4;
   localparam int LANE_DIV1_POS = 16;
   localparam int LANE_DIV_POS = 24;
   localparam int CTRL_APPLY_POS = 0;
   localparam int STAT_APPLIED_POS = 16;
   // ************************************
   // reset values
   // ************************************
   localparam logic [31:0] CLUSTER_RST = 32'h0004_2108;
   localparam logic [31:0] CORE_RST = 32'h0000_0000;
   localparam logic [31:0] MEMORY_RST = 32'h0000_2000;
   localparam logic [31:0] LANE_RST = 32'h0000_0000;
   // ************************************
   // bus answers
   // ************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ************************************
   // decoded clock settings
   // ************************************
   typedef struct packed {
      logic en;
      logic [1:0] range;
      logic [4:0] mult;
   } ccd_pll_s;
   typedef struct packed {
      logic en;
      logic [1:0] pll;
      logic divTwo;
   } ccd_core_s;
   typedef struct packed {
      logic en;
      logic [5:0] mult;
   } ccd_lane_s;
   typedef struct packed {
      logic sync;
      ccd_pll_s pll;
   } ccd_mem_s;
endpackage : ccd_pkg

// ---- ccd_clock_ratio_decoder.sv ----
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module ccd_clock_ratio_decoder #(
   parameter int NUM_CLUSTER = 4,
   parameter int NUM_CORE = 8,
   parameter int NUM_BANK = 3,
   parameter int PAIR_CNT = 5
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // axi4-lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [ccd_pkg::ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [ccd_pkg::ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // decoded clock settings
   output ccd_pkg::ccd_pll_s [NUM_CLUSTER-1:0] clusterPll,
   output ccd_pkg::ccd_core_s [NUM_CORE-1:0] coreClock,
   output ccd_pkg::ccd_mem_s memoryPll,
   output ccd_pkg::ccd_lane_s [NUM_BANK-1:0] lanePll,
   output logic [PAIR_CNT+NUM_BANK-2:0] laneDivTwo,
   output logic configError
);
   import ccd_pkg::*;

   localparam int ERR_W = NUM_CLUSTER + NUM_CORE + 1 + NUM_BANK;

   // ************************************
   // decode functions
   // ************************************
   // cluster multiplier; zero means reserved
   function automatic logic [4:0] clusterMult(input logic [4:0] code);
      logic [4:0] m;
      m = 5'h00;
      case (code)
         5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h0F, 5'h10: m = code;
         default: m = 5'h00;
      endcase
      return m;
   endfunction : clusterMult

   // memory multiplier per mode; zero means reserved
   function automatic logic [4:0] memoryMult(input logic [4:0] code, input logic sync);
      logic [4:0] m;
      m = 5'h00;
      if (sync) begin
         if (code == 5'h01) begin
            m = 5'h01;
         end
      end else begin
         case (code)
            5'h05, 5'h06, 5'h08, 5'h09, 5'h0A, 5'h0C, 5'h0D, 5'h10: m = code;
            default: m = 5'h00;
         endcase
      end
      return m;
   endfunction : memoryMult

   // lane multiplier; the top two only on bank one
   function automatic logic [5:0] laneMult(input logic [2:0] code, input logic bankOne);
      logic [5:0] m;
      m = 6'h00;
      case (code)
         3'h0: m = 6'h0A;
         3'h1: m = 6'h14;
         3'h2: m = 6'h19;
         3'h3: m = bankOne ? 6'h28 : 6'h00;
         3'h4: m = bankOne ? 6'h32 : 6'h00;
         default: m = 6'h00;
      endcase
      return m;
   endfunction : laneMult

   // core select to pll index and divider
   function automatic ccd_core_s coreDecode(input logic [3:0] code, input logic highGroup);
      ccd_core_s c;
      c = '0;
      if (!highGroup) begin
         case (code)
            4'h0: c = '{en: 1'b1, pll: 2'h0, divTwo: 1'b0};
            4'h1: c = '{en: 1'b1, pll: 2'h0, divTwo: 1'b1};
            4'h4: c = '{en: 1'b1, pll: 2'h1, divTwo: 1'b0};
            4'h5: c = '{en: 1'b1, pll: 2'h1, divTwo: 1'b1};
            4'h8: c = '{en: 1'b1, pll: 2'h2, divTwo: 1'b0};
            default: c = '0;
         endcase
      end else begin
         case (code)
            4'h0: c = '{en: 1'b1, pll: 2'h0, divTwo: 1'b0};
            4'h8: c = '{en: 1'b1, pll: 2'h2, divTwo: 1'b0};
            4'h9: c = '{en: 1'b1, pll: 2'h2, divTwo: 1'b1};
            4'hC: c = '{en: 1'b1, pll: 2'h3, divTwo: 1'b0};
            4'hD: c = '{en: 1'b1, pll: 2'h3, divTwo: 1'b1};
            default: c = '0;
         endcase
      end
      return c;
   endfunction : coreDecode

   // byte-lane merge for writes
   function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] val,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = val[b*8 +: 8];
         end
      end
      return r;
   endfunction : mergeBytes

   // ************************************
   // register bus
   // ************************************
   logic [31:0] clusterCfg_ff;
   logic [31:0] coreCfg_ff;
   logic [31:0] memoryCfg_ff;
   logic [31:0] laneCfg_ff;
   logic [ccd_pkg::ADDR_W-1:0] wrAddr_ff;
   logic [31:0] wrData_ff;
   logic [3:0] wrStrb_ff;
   logic haveAddr_ff;
   logic haveData_ff;
   logic applied_ff;
   logic [ERR_W-1:0] nxt_err;
   logic [ERR_W-1:0] err_ff;
   logic doWrite;
   logic applyPulse;
   logic wrMapped;

   assign doWrite = haveAddr_ff && haveData_ff && !bvalid;
   assign wrMapped = (wrAddr_ff[7:2] <= STATUS_OFS[7:2]) && (wrAddr_ff[1:0] == 2'h0);
   assign applyPulse = doWrite && (wrAddr_ff == CONTROL_OFS) && wrStrb_ff[0]
                       && wrData_ff[CTRL_APPLY_POS];

   // address and data captured independently, in either order
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awready <= 1'b1;
         wready <= 1'b1;
         haveAddr_ff <= 1'b0;
         haveData_ff <= 1'b0;
         wrAddr_ff <= '0;
         wrData_ff <= 32'h0000_0000;
         wrStrb_ff <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            wrAddr_ff <= awaddr;
            haveAddr_ff <= 1'b1;
            awready <= 1'b0;
         end else if (doWrite) begin
            haveAddr_ff <= 1'b0;
         end
         if (wvalid && wready) begin
            wrData_ff <= wdata;
            wrStrb_ff <= wstrb;
            haveData_ff <= 1'b1;
            wready <= 1'b0;
         end else if (doWrite) begin
            haveData_ff <= 1'b0;
         end
         // reopen only after the response is taken
         if (bvalid && bready) begin
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // write response one cycle after both halves are in
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (doWrite) begin
         bvalid <= 1'b1;
         bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // configuration registers; status is read-only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clusterCfg_ff <= CLUSTER_RST;
         coreCfg_ff <= CORE_RST;
         memoryCfg_ff <= MEMORY_RST;
         laneCfg_ff <= LANE_RST;
      end else if (doWrite) begin
         if (wrAddr_ff == CLUSTER_OFS) begin
            clusterCfg_ff <= mergeBytes(clusterCfg_ff, wrData_ff, wrStrb_ff);
         end else if (wrAddr_ff == CORE_OFS) begin
            coreCfg_ff <= mergeBytes(coreCfg_ff, wrData_ff, wrStrb_ff);
         end else if (wrAddr_ff == MEMORY_OFS) begin
            memoryCfg_ff <= mergeBytes(memoryCfg_ff, wrData_ff, wrStrb_ff);
         end else if (wrAddr_ff == LANE_OFS) begin
            laneCfg_ff <= mergeBytes(laneCfg_ff, wrData_ff, wrStrb_ff);
         end
      end
   end

   // read answer one cycle after the address is taken
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= RESP_OKAY;
         if (araddr == CLUSTER_OFS) begin
            rdata <= clusterCfg_ff;
         end else if (araddr == CORE_OFS) begin
            rdata <= coreCfg_ff;
         end else if (araddr == MEMORY_OFS) begin
            rdata <= memoryCfg_ff;
         end else if (araddr == LANE_OFS) begin
            rdata <= laneCfg_ff;
         end else if (araddr == CONTROL_OFS) begin
            rdata <= 32'h0000_0000;
         end else if (araddr == STATUS_OFS) begin
            rdata <= 32'(err_ff) | (32'(applied_ff) << STAT_APPLIED_POS);
         end else begin
            rdata <= 32'h0000_0000;
            rresp <= RESP_SLVERR;
         end
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ************************************
   // decode and apply
   // ************************************
   ccd_pll_s [NUM_CLUSTER-1:0] nxtCluster;
   ccd_core_s [NUM_CORE-1:0] nxtCore;
   ccd_mem_s nxtMemory;
   ccd_lane_s [NUM_BANK-1:0] nxtLane;
   logic memModeBad;

   // the loader is trusted for ranges; only codes are checked
   always_comb begin
      nxt_err = '0;
      for (int i = 0; i < NUM_CLUSTER; i++) begin
         nxtCluster[i].mult = clusterMult(clusterCfg_ff[i*CLU_RATIO_W +: CLU_RATIO_W]);
         nxtCluster[i].range = clusterCfg_ff[CLU_RANGE_POS + 2*i +: 2];
         nxtCluster[i].en = (nxtCluster[i].mult != 5'h00);
         nxt_err[i] = !nxtCluster[i].en;
      end
      // a core on a reserved code or a dead pll gets no clock
      for (int i = 0; i < NUM_CORE; i++) begin
         nxtCore[i] = coreDecode(coreCfg_ff[i*CORE_SEL_W +: CORE_SEL_W], i >= NUM_CORE/2);
         if (!nxtCluster[nxtCore[i].pll].en) begin
            nxtCore[i].en = 1'b0;
         end
         nxt_err[NUM_CLUSTER+i] = !nxtCore[i].en;
      end
      // mode bits that disagree leave the mode unknown
      memModeBad = (memoryCfg_ff[MEM_SYNC_POS] != memoryCfg_ff[MEM_RATE_POS])
                   || memoryCfg_ff[MEM_RSV_POS];
      nxtMemory.sync = memoryCfg_ff[MEM_SYNC_POS];
      nxtMemory.pll.mult = memoryMult(memoryCfg_ff[MEM_RATIO_POS +: 5],
                                      memoryCfg_ff[MEM_SYNC_POS]);
      nxtMemory.pll.range = memoryCfg_ff[MEM_RANGE_POS +: 2];
      nxtMemory.pll.en = (nxtMemory.pll.mult != 5'h00) && !memModeBad;
      nxt_err[NUM_CLUSTER+NUM_CORE] = !nxtMemory.pll.en;
      for (int b = 0; b < NUM_BANK; b++) begin
         nxtLane[b].mult = laneMult(laneCfg_ff[b*LANE_RATIO_STEP +: 3], b == 0);
         nxtLane[b].en = (nxtLane[b].mult != 6'h00);
         nxt_err[NUM_CLUSTER+NUM_CORE+1+b] = !nxtLane[b].en;
      end
   end

   // outputs change only on apply so clocks never glitch mid-edit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clusterPll <= '0;
         coreClock <= '0;
         memoryPll <= '0;
         lanePll <= '0;
         laneDivTwo <= '0;
         err_ff <= '0;
         configError <= 1'b0;
         applied_ff <= 1'b0;
      end else if (applyPulse) begin
         clusterPll <= nxtCluster;
         coreClock <= nxtCore;
         memoryPll <= nxtMemory;
         lanePll <= nxtLane;
         // first bit is lanes 0/1, last lanes 12/13
         laneDivTwo[PAIR_CNT-1:0] <= laneCfg_ff[LANE_DIV1_POS +: PAIR_CNT];
         laneDivTwo[PAIR_CNT+NUM_BANK-2:PAIR_CNT] <= laneCfg_ff[LANE_DIV_POS +: NUM_BANK-1];
         err_ff <= nxt_err;
         configError <= |nxt_err;
         applied_ff <= 1'b1;
      end
   end
endmodule : ccd_clock_ratio_decoder

// ---- ccd_decoder_checker.sv ----
`timescale 1ns/1ps
// ************************************
// decoder port checker
// ************************************
module ccd_decoder_checker #(
   parameter int NUM_CLUSTER = 4,
   parameter int NUM_CORE = 8,
   parameter int NUM_BANK = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bus handshakes
   input wire logic awready,
   input wire logic bvalid,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   // decoded settings
   input wire ccd_pkg::ccd_pll_s [NUM_CLUSTER-1:0] clusterPll,
   input wire ccd_pkg::ccd_core_s [NUM_CORE-1:0] coreClock,
   input wire ccd_pkg::ccd_mem_s memoryPll,
   input wire ccd_pkg::ccd_lane_s [NUM_BANK-1:0] lanePll
);
   import ccd_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // a read is taken, then answered on the next edge
   sequence s_rd_taken;
      arvalid && arready;
   endsequence
   sequence s_rd_answer;
      rvalid && !arready;
   endsequence
   a_read_answer: assert property (s_rd_taken |=> s_rd_answer) else $error("read not answered");
   // a taken answer is dropped and the address side reopens
   a_read_release: assert property (rvalid && rready |=> !rvalid && arready) else $error("read answer not released");
   a_write_busy: assert property (bvalid |-> !awready) else $error("address taken while answering");
   // cluster and memory settings move only with the apply response
   a_cfg_hold: assert property ($changed(clusterPll) || $changed(memoryPll) |-> $rose(bvalid))
      else $error("settings moved without apply");
   a_cluster_legal: assert property (clusterPll[0].en |-> clusterPll[0].mult inside {[8:12], 14, 15, 16})
      else $error("cluster ratio reserved");
   a_low_core: assert property (coreClock[0].en |-> coreClock[0].pll != 2'h3
      && !(coreClock[0].pll == 2'h2 && coreClock[0].divTwo))
      else $error("low core select reserved");
   a_high_core: assert property (coreClock[7].en |-> coreClock[7].pll != 2'h1
      && !(coreClock[7].pll == 2'h0 && coreClock[7].divTwo))
      else $error("high core select reserved");
   a_core_source: assert property (coreClock[0].en |-> clusterPll[coreClock[0].pll].en)
      else $error("core fed from idle pll");
   a_mem_sync: assert property (memoryPll.sync && memoryPll.pll.en |-> memoryPll.pll.mult == 5'h01)
      else $error("sync memory ratio");
   a_lane_rate: assert property (lanePll[0].en |-> lanePll[0].mult inside {10, 20, 25, 40, 50})
      else $error("lane ratio reserved");
   a_bank_limit: assert property (lanePll[1].en |-> lanePll[1].mult inside {10, 20, 25})
      else $error("fast lane ratio on bank two");
endmodule : ccd_decoder_checker

bind ccd_clock_ratio_decoder ccd_decoder_checker #(.NUM_CLUSTER(NUM_CLUSTER), .NUM_CORE(NUM_CORE),
   .NUM_BANK(NUM_BANK)) u_ccd_decoder_checker (.clk, .rst_n, .awready, .bvalid, .arvalid, .arready,
   .rvalid, .rready, .rdata, .clusterPll, .coreClock, .memoryPll, .lanePll);

// ---- ccd_cfg_loader.sv ----
`timescale 1ns/1ps
// ************************************
// config word loader, bus master
// ************************************
module ccd_cfg_loader (
   // clock
   input wire logic clk,
   // write side
   output logic awvalid,
   input wire logic awready,
   output logic [ccd_pkg::ADDR_W-1:0] awaddr,
   output logic wvalid,
   input wire logic wready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   input wire logic bvalid,
   output logic bready,
   input wire logic [1:0] bresp,
   // read side
   output logic arvalid,
   input wire logic arready,
   output logic [ccd_pkg::ADDR_W-1:0] araddr,
   input wire logic rvalid,
   output logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp
);
   import ccd_pkg::*;
   // idle bus from time zero
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
   end
   // each channel holds until its own ready; released payload is inverted, not left valid-looking
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw;
      logic w;
      @(posedge clk);
      aw = 1'b1;
      w = 1'b1;
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge clk);
         if (aw && awready) begin
            aw = 1'b0;
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (w && wready) begin
            w = 1'b0;
            wvalid <= 1'b0;
            wdata <= ~d;
         end
      end while (!bvalid);
      bready <= 1'b0;
      r = bresp;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar;
      @(posedge clk);
      ar = 1'b1;
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do begin
         @(posedge clk);
         if (ar && arready) begin
            ar = 1'b0;
            arvalid <= 1'b0;
            araddr <= ~a;
         end
      end while (!rvalid);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
   endtask : rd
endmodule : ccd_cfg_loader

// ---- tb_top.sv ----
`timescale 1ns/1ps
// ************************************
// decoder testbench
// ************************************
module tb_top;
   import ccd_pkg::*;
   localparam logic [31:0] RST_TAB [4] = '{CLUSTER_RST, CORE_RST, MEMORY_RST, LANE_RST};
   localparam logic [5:0] LANE_MULT [8] = '{6'h0A, 6'h14, 6'h19, 6'h28, 6'h32, 6'h00, 6'h00, 6'h00};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   ccd_pll_s [3:0] clusterPll;
   ccd_core_s [7:0] coreClock;
   ccd_mem_s memoryPll;
   ccd_lane_s [2:0] lanePll;
   logic [6:0] laneDivTwo;
   logic configError, ok, hi;
   int errCount = 0;
   int checkCount = 0;
   int cycles = 0;
   int c;
   always #10 clk = ~clk;
   ccd_clock_ratio_decoder u_ccd_clock_ratio_decoder (.clk, .rst_n, .awvalid, .awready, .awaddr, .wvalid,
      .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
      .rdata, .rresp, .clusterPll, .coreClock, .memoryPll, .lanePll, .laneDivTwo, .configError);
   ccd_cfg_loader u_bus (.clk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
      .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
   task automatic printVerdict();
      $display("checks %0d, mismatches %0d", checkCount, errCount);
      if (errCount == 0 && checkCount > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : printVerdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         errCount++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // write a field word, then apply it
   task automatic cfg(input logic [ADDR_W-1:0] a, input logic [31:0] v);
      u_bus.wr(a, v, r);
      chk(r, RESP_OKAY);
      u_bus.wr(CONTROL_OFS, 32'h1, r);
      chk(r, RESP_OKAY);
   endtask : cfg
   // a hung handshake must still reach the verdict
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errCount++;
         printVerdict();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      chk(configError, 0);
      chk(clusterPll, 0);
      for (c = 0; c < 4; c++) begin
         u_bus.rd(8'(c * 4), d, r);
         chk(d, RST_TAB[c]);
      end
      // unmapped places are refused
      u_bus.rd(8'h18, d, r);
      chk(r, RESP_SLVERR);
      chk(d, 32'h0);
      u_bus.wr(8'h1C, 32'hFFFF_FFFF, r);
      chk(r, RESP_SLVERR);
      // every cluster code, ranges set below the 1 GHz mark
      for (c = 0; c < 32; c++) begin
         cfg(CLUSTER_OFS, 32'h0550_0000 | {c[4:0], c[4:0], c[4:0], c[4:0]});
         ok = c inside {[8:12], 14, 15, 16};
         chk(ok ? clusterPll[3] : clusterPll[3].en, ok ? {1'b1, 2'h1, c[4:0]} : 0);
         chk(configError, !ok);
      end
      // every core code on both core groups; all clusters at 8:1 keep shared plls derated
      cfg(CLUSTER_OFS, CLUSTER_RST);
      for (c = 0; c < 16; c++) begin
         cfg(CORE_OFS, {8{c[3:0]}});
         ok = c inside {0, 1, 4, 5, 8};
         hi = c inside {0, 8, 9, 12, 13};
         chk(ok ? coreClock[0] : coreClock[0].en, ok ? {1'b1, c[3:2], c[0]} : 0);
         chk(hi ? coreClock[7] : coreClock[7].en, hi ? {1'b1, c[3:2], c[0]} : 0);
         chk(configError, !(ok && hi));
      end
      d = 32'hDC98_5410;
      cfg(CORE_OFS, d);
      for (c = 0; c < 8; c++)
         chk(coreClock[c], {1'b1, d[c*4+2 +: 2], d[c*4]});
      // every asynchronous memory code
      for (c = 0; c < 32; c++) begin
         cfg(MEMORY_OFS, (32'(c) << 10) | 32'h100);
         ok = c inside {5, 6, 8, 9, 10, 12, 13, 16};
         chk(ok ? memoryPll : memoryPll.pll.en, ok ? {1'b0, 1'b1, 2'h1, c[4:0]} : 0);
         chk(configError, !ok);
      end
      cfg(MEMORY_OFS, 32'h0000_0403);
      chk(memoryPll, {1'b1, 1'b1, 2'h0, 5'h01});
      cfg(MEMORY_OFS, 32'h0000_1403);
      chk({memoryPll.pll.en, configError}, 2'h1);
      cfg(MEMORY_OFS, 32'h0000_2001);
      chk(configError, 1);
      cfg(MEMORY_OFS, 32'h0000_2004);
      chk(configError, 1);
      // only the strobed byte lane lands
      u_bus.wstrb <= 4'h2;
      u_bus.wr(MEMORY_OFS, 32'hFFFF_0500, r);
      u_bus.wstrb <= 4'hF;
      u_bus.rd(MEMORY_OFS, d, r);
      chk(d, 32'h0000_0504);
      // every lane code on the wide and the narrow banks
      cfg(MEMORY_OFS, MEMORY_RST);
      for (c = 0; c < 8; c++) begin
         cfg(LANE_OFS, 32'(c) * 32'h111);
         ok = c < 5;
         hi = c < 3;
         chk(ok ? lanePll[0] : lanePll[0].en, ok ? {1'b1, LANE_MULT[c]} : 0);
         chk(hi ? lanePll[2] : lanePll[2].en, hi ? {1'b1, LANE_MULT[c]} : 0);
         chk(configError, !hi);
      end
      cfg(LANE_OFS, 32'h0116_0000);
      chk(laneDivTwo, 7'h36);
      cfg(LANE_OFS, 32'h0209_0000);
      chk(laneDivTwo, 7'h49);
      // a fast ratio on bank three shows in the status word
      cfg(LANE_OFS, 32'h0000_0300);
      chk(configError, 1);
      u_bus.rd(STATUS_OFS, d, r);
      chk(d, 32'h0001_8000);
      printVerdict();
   end
endmodule : tb_top
